// *** hdl/fsr_defs.vh ***
`ifndef FSR_DEFS_VH
`define FSR_DEFS_VH
// bus address and direction
`define FSR_ADDR         7'h50
`define FSR_DIR_READ     1'b1
// frame layout
`define FSR_FRAME_BYTES  3'h5
`define FSR_LAST_BYTE    3'h4
`define FSR_BIT_LAST     3'h7
`define FSR_FLOW_W       12
`define FSR_HI_PAD       4'h0
// zero-flow count loaded at reset
`define FSR_FLOW_RESET   12'h199
`endif

// *** hdl/fsr_readout.v ***
// Notes on behaviour
// - respond only to 7-bit address 0x50; ignore all others.
// - works with master clock at 100 kHz and 400 kHz.
// - each byte is eight bits plus one response bit; low acknowledges.
// - slave pulls data low in response slot to acknowledge, then releases.
// - data sampled on rising clock; driver holds data stable while clock high.
// - flow measured continuously; a read returns the latest sample, no trigger.
// - every byte leaves most significant bit first.
// - checksum byte goes first, then flow high byte, then low byte.
// - frame is five bytes: checksum then four data bytes covered by it.
// - flow is 12-bit unsigned; high byte upper four bits are zero.
// - checksum is two's complement of modulo-256 sum of data bytes.
`include "fsr_defs.vh"
module fsr_readout (
	input  wire        mclk_in,
	input  wire        arst_n_in,
	input  wire        scl_in,
	input  wire        sda_in,
	output wire        sda_out,
	output reg         sda_oe_out,
	input  wire [11:0] flow_in,
	input  wire        flow_valid_in,
	output reg         busy_out
);
	localparam ST_IDLE = 3'h0;
	localparam ST_ADDR = 3'h1;
	localparam ST_AACK = 3'h2;
	localparam ST_SEND = 3'h3;
	localparam ST_MACK = 3'h4;

	reg        rst_s1;
	reg        rst_n;
	wire       scl;
	wire       sda;
	reg        scl_d;
	reg        sda_d;
	reg  [2:0] state;
	reg  [2:0] bit_cnt;
	reg  [2:0] byte_idx;
	reg  [7:0] shreg;
	reg  [11:0] flow;
	reg  [11:0] flow_snap;
	reg        drive_low;
	reg        addr_done;
	wire [7:0] first_byte;
	wire [7:0] next_byte;

	////////////////////////////////////////////////////////////////////////
	// reset release and pin sampling

	always @(posedge mclk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			rst_s1 <= 1'b0;
			rst_n  <= 1'b0;
		end
		else
		begin
			rst_s1 <= 1'b1;
			rst_n  <= rst_s1;
		end
	end

	fsr_sync u_scl (
		.mclk_in  (mclk_in),
		.rst_n_in (rst_n),
		.d_in     (scl_in),
		.q_out    (scl)
	);

	fsr_sync u_sda (
		.mclk_in  (mclk_in),
		.rst_n_in (rst_n),
		.d_in     (sda_in),
		.q_out    (sda)
	);

	wire scl_rise = scl & ~scl_d;
	wire scl_fall = ~scl & scl_d;
	wire start_c  = scl & scl_d & sda_d & ~sda;
	wire stop_c   = scl & scl_d & ~sda_d & sda;

	////////////////////////////////////////////////////////////////////////
	// frame byte selection

	function [7:0] frame_byte;
		input [2:0]  idx;
		input [11:0] f;
		reg   [7:0]  hi;
		reg   [7:0]  lo;
		begin
			hi = {`FSR_HI_PAD, f[11:8]};
			lo = f[7:0];
			case (idx)
				3'h0:    frame_byte = 8'h00 - (hi + lo + hi + lo);
				3'h1:    frame_byte = hi;
				3'h2:    frame_byte = lo;
				3'h3:    frame_byte = hi;
				3'h4:    frame_byte = lo;
				default: frame_byte = 8'hff;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// latest measurement, refreshed whenever flow_valid_in is high

	always @(posedge mclk_in or negedge rst_n)
	begin
		if (!rst_n)
			flow <= `FSR_FLOW_RESET;
		else if (flow_valid_in)
			flow <= flow_in;
	end

	assign sda_out = 1'b0;

	assign first_byte = frame_byte(3'h0, flow_snap);
	assign next_byte  = frame_byte(byte_idx + 3'h1, flow_snap);

	////////////////////////////////////////////////////////////////////////
	// bus engine; shifts on falling clock, samples on rising

	always @(posedge mclk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scl_d      <= 1'b1;
			sda_d      <= 1'b1;
			state      <= ST_IDLE;
			bit_cnt    <= 3'h0;
			byte_idx   <= 3'h0;
			shreg      <= 8'h00;
			flow_snap  <= `FSR_FLOW_RESET;
			drive_low  <= 1'b0;
			addr_done  <= 1'b0;
			sda_oe_out <= 1'b0;
			busy_out   <= 1'b0;
		end
		else
		begin
			scl_d <= scl;
			sda_d <= sda;
			if (stop_c)
			begin
				state      <= ST_IDLE;
				sda_oe_out <= 1'b0;
				busy_out   <= 1'b0;
			end
			else if (start_c)
			begin
				state      <= ST_ADDR;
				bit_cnt    <= 3'h0;
				addr_done  <= 1'b0;
				sda_oe_out <= 1'b0;
				busy_out   <= 1'b0;
			end
			else
			begin
				case (state)
					ST_IDLE:
						sda_oe_out <= 1'b0;
					ST_ADDR:
					begin
						if (scl_rise)
						begin
							shreg   <= {shreg[6:0], sda};
							bit_cnt <= bit_cnt + 3'h1;
							if (bit_cnt == `FSR_BIT_LAST)
								addr_done <= 1'b1;
						end
						// ack slot opens on the falling edge after bit eight
						// the fall right after start carries no byte, hence the flag
						if (scl_fall && addr_done)
						begin
							addr_done <= 1'b0;
							if (shreg == {`FSR_ADDR, `FSR_DIR_READ})
							begin
								state      <= ST_AACK;
								sda_oe_out <= 1'b1;
								busy_out   <= 1'b1;
								// snapshot so a frame stays self-consistent
								flow_snap  <= flow;
							end
							else
								state <= ST_IDLE;
						end
					end
					ST_AACK:
						if (scl_fall)
						begin
							state     <= ST_SEND;
							byte_idx  <= 3'h0;
							bit_cnt   <= 3'h0;
							shreg      <= first_byte;
							drive_low  <= 1'b0;
							sda_oe_out <= ~first_byte[`FSR_BIT_LAST];
						end
					ST_SEND:
						if (scl_fall)
						begin
							if (bit_cnt == `FSR_BIT_LAST)
							begin
								state      <= ST_MACK;
								sda_oe_out <= 1'b0;
							end
							else
							begin
								bit_cnt    <= bit_cnt + 3'h1;
								shreg      <= {shreg[6:0], 1'b0};
								sda_oe_out <= ~shreg[6];
							end
						end
					ST_MACK:
					begin
						if (scl_rise)
							drive_low <= sda; // remember response
						if (scl_fall)
						begin
							if (drive_low || byte_idx == `FSR_LAST_BYTE)
							begin
								state      <= ST_IDLE;
								sda_oe_out <= 1'b0;
								busy_out   <= 1'b0;
							end
							else
							begin
								state      <= ST_SEND;
								byte_idx   <= byte_idx + 3'h1;
								bit_cnt    <= 3'h0;
								shreg      <= next_byte;
								sda_oe_out <= ~next_byte[`FSR_BIT_LAST];
							end
						end
					end
					default:
						state <= ST_IDLE;
				endcase
			end
		end
	end
endmodule

// *** hdl/fsr_sync.v ***
`include "fsr_defs.vh"
module fsr_sync (
	input  wire mclk_in,
	input  wire rst_n_in,
	input  wire d_in,
	output reg  q_out
);
	reg s1;
	reg s2;
	reg s3;
	// first stage feeds only the second; change accepted when 2 and 3 agree
	always @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			s1    <= 1'b1;
			s2    <= 1'b1;
			s3    <= 1'b1;
			q_out <= 1'b1;
		end
		else
		begin
			s1 <= d_in;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				q_out <= s3;
		end
	end
endmodule

// *** verif/fsr_master_model.sv ***
module fsr_master_model (
	output logic scl_out,
	output logic pull_out,
	input  wire  sda_in
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		scl_out = 1'b1;
		pull_out = 1'b0;
	end
	// long low phase leaves the slave time to move its drive
	task automatic xfer(input logic b, output logic r);
		#12 pull_out = !b;
		#28 scl_out = 1'b1;
		#24 r = sda_in;
		scl_out = 1'b0;
	endtask
	task automatic read_frame(input logic [7:0] hdr, input int n,
		output logic [39:0] q, output logic ack);
		logic r;
		#40 pull_out = 1'b1;
		#24 scl_out = 1'b0;
		for (int i = 7; i >= 0; i--) xfer(hdr[i], r);
		xfer(1'b1, r);
		ack = !r;
		for (int k = 0; k < 5; k++)
		begin
			for (int i = 0; i < 8; i++)
			begin
				xfer(1'b1, r);
				q = {q[38:0], r};
			end
			xfer(k >= n || k == 4, r);
		end
		#12 pull_out = 1'b1;
		#28 scl_out = 1'b1;
		#24 pull_out = 1'b0;
	endtask
endmodule

// *** verif/fsr_readout_checker.sv ***
module fsr_readout_checker (
	input wire mclk_in,
	input wire arst_n_in,
	input wire scl_in,
	input wire sda_in,
	input wire sda_out,
	input wire sda_oe_out,
	input wire busy_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!arst_n_in);
	sequence s_start; scl_in && $past(scl_in) && $fell(sda_in); endsequence
	sequence s_stop; scl_in && $past(scl_in) && $rose(sda_in); endsequence
	property p_lo; sda_out == 1'b0; endproperty
	a_lo: assert property (p_lo) else $error("pin value");
	property p_rst; $rose(arst_n_in) |-> (!busy_out && !sda_oe_out) [*2]; endproperty
	a_rst: assert property (p_rst) else $error("active after reset");
	// the change is seen one edge late, so the clock level at the change edge counts
	property p_mv; $changed(sda_oe_out) |-> !$past(scl_in); endproperty
	a_mv: assert property (p_mv) else $error("drive moved, clock high");
	property p_hold; scl_in && $past(scl_in) |-> $stable(sda_oe_out); endproperty
	a_hold: assert property (p_hold) else $error("drive unstable");
	property p_stop; s_stop |-> ##[1:8] !busy_out && !sda_oe_out; endproperty
	a_stop: assert property (p_stop) else $error("busy after stop");
	property p_start; s_start |-> ##[1:8] !busy_out; endproperty
	a_start: assert property (p_start) else $error("busy after start");
	property p_ack; $rose(busy_out) |-> ##[0:2] sda_oe_out; endproperty
	a_ack: assert property (p_ack) else $error("no address ack");
	property p_end; $fell(busy_out) |-> ##[0:8] !sda_oe_out; endproperty
	a_end: assert property (p_end) else $error("drive after frame");
endmodule
////////////////////////////////////////////////////////////////
bind fsr_readout fsr_readout_checker u_chk (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
	.scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
	.busy_out(busy_out));

// *** verif/fsr_readout_test.sv ***
module fsr_readout_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk_in = 1'b0;
	logic        arst_n_in = 1'b0;
	logic [11:0] flow_in = 12'h000;
	logic        flow_valid_in = 1'b0;
	wire         scl, pull, sda_oe_out, sda_out, busy_out;
	wire         sda = !(sda_oe_out || pull);
	int          fails = 0;
	int          cmp_count = 0;
	logic [39:0] q;
	logic        ack;
	// header byte, flow, first master nack
	logic [27:0] rows [5] = '{{8'ha1, 12'he66, 8'h5}, {8'ha1, 12'h0ff, 8'h1},
		{8'ha1, 12'hfff, 8'h0}, {8'ha0, 12'h123, 8'h5}, {8'ha3, 12'h123, 8'h5}};
	always #4 mclk_in = !mclk_in;
	fsr_master_model u_mst (.scl_out(scl), .pull_out(pull), .sda_in(sda));
	fsr_readout u_dut (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe_out(sda_oe_out), .flow_in(flow_in),
		.flow_valid_in(flow_valid_in), .busy_out(busy_out));
	////////////////////////////////////////////////////////////////
	function automatic logic [39:0] frame(input logic [11:0] f, input int n);
		logic [7:0]  hi;
		logic [39:0] v;
		hi = {4'h0, f[11:8]};
		v = {8'h00 - ((hi + f[7:0]) << 1), hi, f[7:0], hi, f[7:0]};
		for (int k = n + 1; k < 5; k++) v[39 - 8 * k -: 8] = 8'hff;
		return v;
	endfunction
	// reader side count to litres per minute, integer part
	function automatic int lpm(input logic [39:0] v);
		return (int'({v[27:24], v[23:16]}) - 409) * 200 / 3277;
	endfunction
	task automatic check(input string what, input logic [39:0] seen, exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic load(input logic [11:0] f);
		@(posedge mclk_in) #1 flow_in = f;
		flow_valid_in = 1'b1;
		@(posedge mclk_in) #1 flow_valid_in = 1'b0;
	endtask
	task automatic run(input logic [7:0] hdr, input logic [11:0] f, input int n);
		u_mst.read_frame(hdr, n, q, ack);
		check("ack", 40'(ack), 40'(hdr == 8'ha1));
		check("frame", q, frame(f, hdr == 8'ha1 ? n : -1));
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		#100us;
		fails++;
		stop_test;
	end
	initial
	begin
		repeat (10) @(posedge mclk_in);
		#1 arst_n_in = 1'b1;
		repeat (10) @(posedge mclk_in);
		foreach (rows[i])
		begin
			load(rows[i][19:8]);
			run(rows[i][27:20], rows[i][19:8], int'(rows[i][7:0]));
		end
		// latest of two back-to-back samples wins, no trigger needed
		load(12'h321);
		load(12'h654);
		run(8'ha1, 12'h654, 5);
		load(12'he66);
		run(8'ha1, 12'he66, 5);
		check("full scale lpm", 40'(lpm(q)), 40'd200);
		@(posedge mclk_in) #1 arst_n_in = 1'b0;
		repeat (3) @(posedge mclk_in);
		#1 arst_n_in = 1'b1;
		repeat (10) @(posedge mclk_in);
		run(8'ha1, 12'h199, 5);
		check("zero flow lpm", 40'(lpm(q)), 40'd0);
		stop_test;
	end
endmodule
